/* verilog/mcpi_pkg.sv */
/*
  Shared constants, encodings and the configuration word layout for the
  motor control pin interface. Assumes a single 100 MHz core clock.
*/
package mcpi_pkg;
  // ********************************************************************
  // Clock and timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_TICK_NS = 1000;
  localparam int RAMP_TICK_CYC = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALIGN_TIME_NS = 10000;
  localparam int ALIGN_CYC = (ALIGN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_NS = 100000;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;
  localparam int MEAS_WINDOW_CYC = 256;
  localparam int MEAS_CNT_W = 9;

  // ********************************************************************
  // Widths and pin slots
  // ********************************************************************
  localparam int SPD_W = 8;
  localparam int ACC_W = 16;
  localparam int FAULT_W = 8;
  localparam int FAULT_COAST_BIT = 7;
  localparam int PIN_NUM = 4;
  localparam int PIN_BRAKE = 0;
  localparam int PIN_DIR = 1;
  localparam int PIN_OUTPUT_DISABLE_PIN = 2;
  localparam int PIN_SPEED = 3;
  localparam logic [SPD_W-1:0] SPD_ZERO = 8'h00;
  localparam logic [SPD_W-1:0] SPD_MAX = 8'hFF;
  localparam logic [SPD_W-1:0] WAKE_ANALOG_THR = 8'h10;
  localparam logic [1:0] POS_FIRST = 2'h0;
  localparam logic [1:0] POS_LAST = 2'h2;
  localparam logic [2:0] PH_A = 3'h1;
  localparam logic [2:0] PH_B = 3'h2;
  localparam logic [2:0] PH_C = 3'h4;
  localparam logic [2:0] PH_NONE = 3'h0;
  localparam logic [2:0] PH_ALL = 3'h7;

  // ********************************************************************
  // Encodings
  // ********************************************************************
  typedef enum logic [1:0] {
    MCPI_SPD_PWM = 2'h0,
    MCPI_SPD_FREQ = 2'h1,
    MCPI_SPD_ANALOG = 2'h2,
    MCPI_SPD_I2C = 2'h3
  } mcpi_spd_mode_t;

  typedef enum logic [2:0] {
    MCPI_ST_IDLE = 3'h0,
    MCPI_ST_RESTART = 3'h1,
    MCPI_ST_RUN = 3'h3,
    MCPI_ST_BRAKE_RAMP = 3'h2,
    MCPI_ST_BRAKE = 3'h6,
    MCPI_ST_COAST = 3'h4
  } mcpi_motor_state_t;

  typedef enum logic [1:0] {
    MCPI_PWR_ACTIVE = 2'h0,
    MCPI_PWR_STANDBY = 2'h1,
    MCPI_PWR_SLEEP = 2'h3
  } mcpi_pwr_t;

  typedef struct packed {
    logic [SPD_W-1:0] i2c_speed;
    logic [SPD_W-1:0] brake_speed_thr;
    logic [3:0] ramp_step;
    logic sleep_sel;
    logic dir_ovr_val;
    logic dir_ovr_en;
    logic brake_ovr_val;
    logic brake_ovr_en;
    logic brake_align;
    mcpi_spd_mode_t speed_mode;
  } mcpi_cfg_t;

  localparam int CFG_W = 28;
  localparam logic [CFG_W-1:0] CFG_RESET_VAL = 28'h0000000;
endpackage

/* verilog/mcpi_speed_if.sv */
/*
  Carrier between the core and the speed input decoder.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ns
interface mcpi_speed_if;
  logic pin_level;
  mcpi_pkg::mcpi_spd_mode_t mode;
  logic [mcpi_pkg::SPD_W-1:0] adc_code;
  logic [mcpi_pkg::SPD_W-1:0] i2c_cmd;
  logic [mcpi_pkg::SPD_W-1:0] speed_cmd;
  logic wake;

  modport meas (input pin_level, input mode, input adc_code, input i2c_cmd, output speed_cmd, output wake);
  modport core (output pin_level, output mode, output adc_code, output i2c_cmd, input speed_cmd, input wake);
endinterface

/* verilog/mcpi_sync.sv */
/*
  Two-stage synchroniser bank for asynchronous control pins.
  Assumes inputs may change at any time relative to clk_in.
*/
`timescale 1ns/1ns
module mcpi_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk_in)
      begin
        if (reset_in)
        begin
          meta_ff[i] <= 1'b0;
          sync_ff[i] <= 1'b0;
        end
        else
        begin
          meta_ff[i] <= async_in[i];
          sync_ff[i] <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_ff;
endmodule // mcpi_sync

/* verilog/mcpi_speed_meas.sv */
/*
  Speed input decoder: duty, frequency, analog or serial command.
  Assumes pin_level is already synchronised to clk_in.
*/
`timescale 1ns/1ns
module mcpi_speed_meas (
  input wire logic clk_in,
  input wire logic reset_in,
  mcpi_speed_if.meas spd
);
  logic pin_d_ff;
  logic [mcpi_pkg::MEAS_CNT_W-1:0] win_cnt_ff;
  logic [mcpi_pkg::MEAS_CNT_W-1:0] high_cnt_ff;
  logic [mcpi_pkg::MEAS_CNT_W-1:0] edge_cnt_ff;
  logic [mcpi_pkg::SPD_W-1:0] duty_ff;
  logic [mcpi_pkg::SPD_W-1:0] freq_ff;
  logic win_end;

  assign win_end = (win_cnt_ff == mcpi_pkg::MEAS_CNT_W'(mcpi_pkg::MEAS_WINDOW_CYC - 1));

  // Saturating window count; 256 would wrap to zero otherwise
  function automatic logic [mcpi_pkg::SPD_W-1:0] sat_cnt(input logic [mcpi_pkg::MEAS_CNT_W-1:0] c);
    sat_cnt = c[mcpi_pkg::MEAS_CNT_W-1] ? mcpi_pkg::SPD_MAX : c[mcpi_pkg::SPD_W-1:0];
  endfunction

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pin_d_ff <= 1'b0;
      win_cnt_ff <= '0;
      high_cnt_ff <= '0;
      edge_cnt_ff <= '0;
      duty_ff <= mcpi_pkg::SPD_ZERO;
      freq_ff <= mcpi_pkg::SPD_ZERO;
    end
    else
    begin
      pin_d_ff <= spd.pin_level;
      if (win_end)
      begin
        win_cnt_ff <= '0;
        high_cnt_ff <= '0;
        edge_cnt_ff <= '0;
        duty_ff <= sat_cnt(high_cnt_ff + MEAS_ONE(spd.pin_level));
        freq_ff <= sat_cnt(edge_cnt_ff + MEAS_ONE(spd.pin_level & ~pin_d_ff));
      end
      else
      begin
        win_cnt_ff <= win_cnt_ff + 1'b1;
        high_cnt_ff <= high_cnt_ff + MEAS_ONE(spd.pin_level);
        edge_cnt_ff <= edge_cnt_ff + MEAS_ONE(spd.pin_level & ~pin_d_ff);
      end
    end
  end

  function automatic logic [mcpi_pkg::MEAS_CNT_W-1:0] MEAS_ONE(input logic b);
    MEAS_ONE = {{(mcpi_pkg::MEAS_CNT_W-1){1'b0}}, b};
  endfunction

  always_comb
  begin
    case (spd.mode)
      mcpi_pkg::MCPI_SPD_PWM: spd.speed_cmd = duty_ff;
      mcpi_pkg::MCPI_SPD_FREQ: spd.speed_cmd = freq_ff;
      mcpi_pkg::MCPI_SPD_ANALOG: spd.speed_cmd = spd.adc_code;
      default: spd.speed_cmd = spd.i2c_cmd;
    endcase
  end

  assign spd.wake = (spd.mode == mcpi_pkg::MCPI_SPD_ANALOG) ? (spd.adc_code > mcpi_pkg::WAKE_ANALOG_THR) :
                    spd.pin_level;
endmodule // mcpi_speed_meas

/* verilog/mcpi_top.sv */
/*
  Pin-level motor control: speed/wake, brake, direction, output disable,
  fault pin and configuration store. Assumes pins are asynchronous, the
  ADC code and fault events come from logic on clk_in, and an external
  non-volatile store presents its image on nvm_rd_data_in at reset.
*/
//
// Overview of operation
// - Brake held while brake input high
// - Brake style: low-side or align
// - Ramp down to threshold before braking
// - Serial override replaces brake pin
// - Direction high A-B-C, low A-C-B
// - Serial override replaces direction pin
// - Output disable forces coast, flags fault if in run state
// - Release of disable runs restart sequence
// - Output disable never sleeps the core
// - Only speed pin enters/leaves sleep
// - Speed pin sets speed and wakes
// - Speed pin: duty, frequency or analog
// - Speed from pin, analog or serial
// - Active-low fault pin, sticky fault status
// - Fixed state machine steered by settings
// - Settings saved to non-volatile store
`timescale 1ns/1ns
module mcpi_top #(
  parameter int SLEEP_ENTRY_CYC = mcpi_pkg::SLEEP_ENTRY_CYC
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic brake_pin_in,
  input wire logic dir_pin_in,
  input wire logic output_disable_pin_in,
  input wire logic speed_wake_pin_in,
  input wire logic [mcpi_pkg::SPD_W-1:0] adc_speed_code_in,
  input wire logic cfg_wr_in,
  input wire logic [mcpi_pkg::CFG_W-1:0] cfg_data_in,
  input wire logic nvm_save_in,
  input wire logic [mcpi_pkg::CFG_W-1:0] nvm_rd_data_in,
  input wire logic [mcpi_pkg::FAULT_W-1:0] fault_events_in,
  input wire logic [mcpi_pkg::FAULT_W-1:0] fault_clear_in,
  output logic [2:0] hs_en_out,
  output logic [2:0] ls_en_out,
  output logic [2:0] motor_state_out,
  output logic [1:0] power_state_out,
  output logic [mcpi_pkg::SPD_W-1:0] speed_ref_out,
  output logic [mcpi_pkg::SPD_W-1:0] speed_cmd_out,
  output logic dir_eff_out,
  output logic fault_indicator_n_out,
  output logic [mcpi_pkg::FAULT_W-1:0] fault_status_out,
  output logic [mcpi_pkg::CFG_W-1:0] cfg_out,
  output logic nvm_wr_out,
  output logic [mcpi_pkg::CFG_W-1:0] nvm_wr_data_out
);
  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic [mcpi_pkg::PIN_NUM-1:0] pins_sync;
  mcpi_pkg::mcpi_cfg_t cfg_ff;
  logic boot_load_ff;
  logic nvm_wr_ff;
  logic [mcpi_pkg::CFG_W-1:0] nvm_wr_data_ff;
  mcpi_pkg::mcpi_motor_state_t state_ff;
  mcpi_pkg::mcpi_motor_state_t nxt_state;
  mcpi_pkg::mcpi_pwr_t pwr_ff;
  logic [mcpi_pkg::TIMER_W-1:0] sleep_cnt_ff;
  logic [mcpi_pkg::TIMER_W-1:0] align_cnt_ff;
  logic [mcpi_pkg::TIMER_W-1:0] ramp_div_ff;
  logic ramp_tick;
  logic [mcpi_pkg::SPD_W-1:0] speed_ref_ff;
  logic [mcpi_pkg::SPD_W-1:0] nxt_speed_ref;
  logic [mcpi_pkg::SPD_W-1:0] speed_cmd_ff;
  logic [mcpi_pkg::ACC_W-1:0] acc_ff;
  logic [1:0] pos_ff;
  logic [2:0] hs_en_ff;
  logic [2:0] ls_en_ff;
  logic [2:0] nxt_hs;
  logic [2:0] nxt_ls;
  logic dir_eff_ff;
  logic [mcpi_pkg::FAULT_W-1:0] fault_ff;
  logic [mcpi_pkg::FAULT_W-1:0] nxt_fault;
  logic fault_n_ff;
  logic brake_eff;
  logic dir_eff;
  logic drv_off;
  logic align_done;
  logic step;
  logic [mcpi_pkg::ACC_W:0] acc_sum;
  logic [mcpi_pkg::SPD_W:0] ramp_up;
  logic [mcpi_pkg::SPD_W-1:0] ramp_step;

  mcpi_speed_if spd_if ();

  // ********************************************************************
  // Pin synchronisers and speed decoder
  // ********************************************************************
  mcpi_sync #(
    .WIDTH(mcpi_pkg::PIN_NUM)
  ) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .async_in({speed_wake_pin_in, output_disable_pin_in, dir_pin_in, brake_pin_in}),
    .sync_out(pins_sync)
  );

  assign spd_if.pin_level = pins_sync[mcpi_pkg::PIN_SPEED];
  assign spd_if.mode = cfg_ff.speed_mode;
  assign spd_if.adc_code = adc_speed_code_in;
  assign spd_if.i2c_cmd = cfg_ff.i2c_speed;

  mcpi_speed_meas u_meas (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .spd(spd_if.meas)
  );

  assign brake_eff = cfg_ff.brake_ovr_en ? cfg_ff.brake_ovr_val : pins_sync[mcpi_pkg::PIN_BRAKE];
  assign dir_eff = cfg_ff.dir_ovr_en ? cfg_ff.dir_ovr_val : pins_sync[mcpi_pkg::PIN_DIR];
  assign drv_off = pins_sync[mcpi_pkg::PIN_OUTPUT_DISABLE_PIN];

  // ********************************************************************
  // Configuration store
  // ********************************************************************
  // Boot load and save to store
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      cfg_ff <= mcpi_pkg::mcpi_cfg_t'(mcpi_pkg::CFG_RESET_VAL);
      boot_load_ff <= 1'b1;
      nvm_wr_ff <= 1'b0;
      nvm_wr_data_ff <= mcpi_pkg::CFG_RESET_VAL;
    end
    else
    begin
      boot_load_ff <= 1'b0;
      nvm_wr_ff <= nvm_save_in & ~boot_load_ff;
      if (nvm_save_in & ~boot_load_ff)
      begin
        nvm_wr_data_ff <= cfg_ff;
      end
      // Image taken once after release, so a strap-like level is never reset logic
      if (boot_load_ff)
      begin
        cfg_ff <= mcpi_pkg::mcpi_cfg_t'(nvm_rd_data_in);
      end
      else if (cfg_wr_in)
      begin
        cfg_ff <= mcpi_pkg::mcpi_cfg_t'(cfg_data_in);
      end
    end
  end

  // ********************************************************************
  // Power state
  // ********************************************************************
  // Sleep entry and exit from speed pin
  // Output disable plays no part here
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pwr_ff <= mcpi_pkg::MCPI_PWR_ACTIVE;
      sleep_cnt_ff <= '0;
    end
    else if (spd_if.wake)
    begin
      pwr_ff <= mcpi_pkg::MCPI_PWR_ACTIVE;
      sleep_cnt_ff <= '0;
    end
    else if (pwr_ff == mcpi_pkg::MCPI_PWR_ACTIVE)
    begin
      if (sleep_cnt_ff == mcpi_pkg::TIMER_W'(SLEEP_ENTRY_CYC - 1))
      begin
        pwr_ff <= cfg_ff.sleep_sel ? mcpi_pkg::MCPI_PWR_SLEEP : mcpi_pkg::MCPI_PWR_STANDBY;
        sleep_cnt_ff <= '0;
      end
      else
      begin
        sleep_cnt_ff <= sleep_cnt_ff + 1'b1;
      end
    end
  end

  // ********************************************************************
  // Motor state machine
  // ********************************************************************
  assign align_done = (align_cnt_ff == mcpi_pkg::TIMER_W'(mcpi_pkg::ALIGN_CYC - 1));

  always_comb
  begin
    nxt_state = state_ff;
    if (pwr_ff != mcpi_pkg::MCPI_PWR_ACTIVE)
    begin
      nxt_state = mcpi_pkg::MCPI_ST_IDLE;
    end
    else if (drv_off)
    begin
      nxt_state = mcpi_pkg::MCPI_ST_COAST;
    end
    else
    begin
      case (state_ff)
        mcpi_pkg::MCPI_ST_IDLE:
          if (brake_eff)
            nxt_state = mcpi_pkg::MCPI_ST_BRAKE_RAMP;
          else if (spd_if.speed_cmd != mcpi_pkg::SPD_ZERO)
            nxt_state = mcpi_pkg::MCPI_ST_RESTART;
        mcpi_pkg::MCPI_ST_RESTART:
          if (brake_eff)
            nxt_state = mcpi_pkg::MCPI_ST_BRAKE_RAMP;
          else if (align_done)
            nxt_state = mcpi_pkg::MCPI_ST_RUN;
        mcpi_pkg::MCPI_ST_RUN:
          if (brake_eff)
            nxt_state = mcpi_pkg::MCPI_ST_BRAKE_RAMP;
          else if (spd_if.speed_cmd == mcpi_pkg::SPD_ZERO && speed_ref_ff == mcpi_pkg::SPD_ZERO)
            nxt_state = mcpi_pkg::MCPI_ST_IDLE;
        // Brake only at or below threshold
        mcpi_pkg::MCPI_ST_BRAKE_RAMP:
          if (!brake_eff)
            nxt_state = mcpi_pkg::MCPI_ST_RUN;
          else if (speed_ref_ff <= cfg_ff.brake_speed_thr)
            nxt_state = mcpi_pkg::MCPI_ST_BRAKE;
        mcpi_pkg::MCPI_ST_BRAKE:
          if (!brake_eff)
            nxt_state = (spd_if.speed_cmd != mcpi_pkg::SPD_ZERO) ? mcpi_pkg::MCPI_ST_RESTART :
                        mcpi_pkg::MCPI_ST_IDLE;
        mcpi_pkg::MCPI_ST_COAST:
          nxt_state = mcpi_pkg::MCPI_ST_RESTART;
        default:
          nxt_state = mcpi_pkg::MCPI_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      state_ff <= mcpi_pkg::MCPI_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Align timer restarts on every entry to the restart sequence
  always_ff @(posedge clk_in)
  begin
    if (reset_in || state_ff != mcpi_pkg::MCPI_ST_RESTART)
      align_cnt_ff <= '0;
    else if (!align_done)
      align_cnt_ff <= align_cnt_ff + 1'b1;
  end

  // ********************************************************************
  // Speed ramp
  // ********************************************************************
  assign ramp_tick = (ramp_div_ff == mcpi_pkg::TIMER_W'(mcpi_pkg::RAMP_TICK_CYC - 1));
  assign ramp_step = {4'h0, cfg_ff.ramp_step};
  assign ramp_up = {1'b0, speed_ref_ff} + {1'b0, ramp_step};

  always_ff @(posedge clk_in)
  begin
    if (reset_in || ramp_tick)
      ramp_div_ff <= '0;
    else
      ramp_div_ff <= ramp_div_ff + 1'b1;
  end

  // Ramp toward command while running, toward zero while brake pending
  always_comb
  begin
    nxt_speed_ref = speed_ref_ff;
    if (state_ff == mcpi_pkg::MCPI_ST_RUN && ramp_tick)
    begin
      if (speed_ref_ff < spd_if.speed_cmd)
        nxt_speed_ref = (ramp_up > {1'b0, spd_if.speed_cmd}) ? spd_if.speed_cmd : ramp_up[mcpi_pkg::SPD_W-1:0];
      else if (speed_ref_ff - spd_if.speed_cmd > ramp_step)
        nxt_speed_ref = speed_ref_ff - ramp_step;
      else
        nxt_speed_ref = spd_if.speed_cmd;
    end
    else if (state_ff == mcpi_pkg::MCPI_ST_BRAKE_RAMP && ramp_tick)
    begin
      nxt_speed_ref = (speed_ref_ff > ramp_step) ? speed_ref_ff - ramp_step : mcpi_pkg::SPD_ZERO;
    end
    else if (state_ff != mcpi_pkg::MCPI_ST_RUN && state_ff != mcpi_pkg::MCPI_ST_BRAKE_RAMP)
    begin
      nxt_speed_ref = mcpi_pkg::SPD_ZERO;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      speed_ref_ff <= mcpi_pkg::SPD_ZERO;
      speed_cmd_ff <= mcpi_pkg::SPD_ZERO;
    end
    else
    begin
      speed_ref_ff <= nxt_speed_ref;
      speed_cmd_ff <= spd_if.speed_cmd;
    end
  end

  // ********************************************************************
  // Commutation
  // ********************************************************************
  assign acc_sum = {1'b0, acc_ff} + {{(mcpi_pkg::ACC_W-mcpi_pkg::SPD_W+1){1'b0}}, speed_ref_ff};
  assign step = acc_sum[mcpi_pkg::ACC_W];

  always_ff @(posedge clk_in)
  begin
    if (reset_in || state_ff == mcpi_pkg::MCPI_ST_RESTART)
    begin
      acc_ff <= '0;
      pos_ff <= mcpi_pkg::POS_FIRST;
    end
    else
    begin
      acc_ff <= acc_sum[mcpi_pkg::ACC_W-1:0];
      if (step)
        pos_ff <= (pos_ff == mcpi_pkg::POS_LAST) ? mcpi_pkg::POS_FIRST : pos_ff + 1'b1;
    end
  end

  function automatic logic [2:0] phase_of(input logic [1:0] pos, input logic dir);
    case (pos)
      2'h0: phase_of = mcpi_pkg::PH_A;
      2'h1: phase_of = dir ? mcpi_pkg::PH_B : mcpi_pkg::PH_C;
      default: phase_of = dir ? mcpi_pkg::PH_C : mcpi_pkg::PH_B;
    endcase
  endfunction

  // Bridge pattern per state; coast keeps every switch off
  always_comb
  begin
    nxt_hs = mcpi_pkg::PH_NONE;
    nxt_ls = mcpi_pkg::PH_NONE;
    case (nxt_state)
      mcpi_pkg::MCPI_ST_RESTART:
      begin
        nxt_hs = mcpi_pkg::PH_A;
        nxt_ls = mcpi_pkg::PH_B | mcpi_pkg::PH_C;
      end
      mcpi_pkg::MCPI_ST_RUN, mcpi_pkg::MCPI_ST_BRAKE_RAMP:
      begin
        nxt_hs = phase_of(pos_ff, dir_eff);
        nxt_ls = phase_of((pos_ff == mcpi_pkg::POS_LAST) ? mcpi_pkg::POS_FIRST : pos_ff + 1'b1, dir_eff);
      end
      mcpi_pkg::MCPI_ST_BRAKE:
      begin
        nxt_hs = cfg_ff.brake_align ? mcpi_pkg::PH_A : mcpi_pkg::PH_NONE;
        nxt_ls = cfg_ff.brake_align ? (mcpi_pkg::PH_B | mcpi_pkg::PH_C) : mcpi_pkg::PH_ALL;
      end
      default:
      begin
        nxt_hs = mcpi_pkg::PH_NONE;
        nxt_ls = mcpi_pkg::PH_NONE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      hs_en_ff <= mcpi_pkg::PH_NONE;
      ls_en_ff <= mcpi_pkg::PH_NONE;
      dir_eff_ff <= 1'b0;
    end
    else
    begin
      hs_en_ff <= nxt_hs;
      ls_en_ff <= nxt_ls;
      dir_eff_ff <= dir_eff;
    end
  end

  // ********************************************************************
  // Faults
  // ********************************************************************
  // Disable while in the run state flags a fault
  // Sticky status, set wins over clear
  always_comb
  begin
    nxt_fault = (fault_ff & ~fault_clear_in) | fault_events_in;
    if (drv_off && state_ff == mcpi_pkg::MCPI_ST_RUN)
      nxt_fault[mcpi_pkg::FAULT_COAST_BIT] = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      fault_ff <= '0;
      fault_n_ff <= 1'b1;
    end
    else
    begin
      fault_ff <= nxt_fault;
      fault_n_ff <= ~|nxt_fault;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign hs_en_out = hs_en_ff;
  assign ls_en_out = ls_en_ff;
  assign motor_state_out = state_ff;
  assign power_state_out = pwr_ff;
  assign speed_ref_out = speed_ref_ff;
  assign speed_cmd_out = speed_cmd_ff;
  assign dir_eff_out = dir_eff_ff;
  assign fault_indicator_n_out = fault_n_ff;
  assign fault_status_out = fault_ff;
  assign cfg_out = cfg_ff;
  assign nvm_wr_out = nvm_wr_ff;
  assign nvm_wr_data_out = nvm_wr_data_ff;
endmodule // mcpi_top

/* verification/mcpi_top_chk.sv */
/* Checker on mcpi_top ports: bridge, brake, direction, power, faults.
   Assumes one clock and synchronous reset_in. */
`timescale 1ns/1ns
module mcpi_top_chk (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic brake_pin_in,
  input wire logic dir_pin_in,
  input wire logic output_disable_pin_in,
  input wire logic [2:0] hs_en_out,
  input wire logic [2:0] ls_en_out,
  input wire logic [2:0] motor_state_out,
  input wire logic [1:0] power_state_out,
  input wire logic [7:0] speed_ref_out,
  input wire logic dir_eff_out,
  input wire logic fault_indicator_n_out,
  input wire logic [7:0] fault_status_out,
  input wire logic [27:0] cfg_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  a_fault_pin_low:
    assert property (fault_indicator_n_out == (fault_status_out == 8'h00)) else $error("fault pin wrong");
  a_coast_all_off:
    assert property (motor_state_out == 3'h4 |-> {hs_en_out, ls_en_out} == 6'h00) else $error("coast drives");
  a_low_side_brake:
    assert property (motor_state_out == 3'h6 && !$past(cfg_out[2]) |-> {hs_en_out, ls_en_out} == 6'h07)
      else $error("ls brake");
  a_align_brake:
    assert property (motor_state_out == 3'h6 && $past(cfg_out[2]) |-> {hs_en_out, ls_en_out} == 6'h0E)
      else $error("align");
  a_brake_hold:
    assert property ((brake_pin_in && !output_disable_pin_in && !cfg_out[3] && power_state_out == 2'h0
      && motor_state_out == 3'h6) [*3] |=> motor_state_out == 3'h6) else $error("brake left");
  a_brake_thr:
    assert property (motor_state_out == 3'h6 && $past(motor_state_out) == 3'h2 |-> speed_ref_out <= cfg_out[19:12])
      else $error("brake too fast");
  a_phase_order:
    assert property (motor_state_out == 3'h3 && hs_en_out == 3'h1 |-> ls_en_out == (dir_eff_out ? 3'h2 : 3'h4))
      else $error("phase order");
  a_dir_select:
    assert property ($stable({cfg_out[6:5], dir_pin_in}) [*4] |-> dir_eff_out == (cfg_out[5] ? cfg_out[6] : dir_pin_in))
      else $error("direction wrong");
  a_sleep_idle:
    assert property ($past(power_state_out) != 2'h0 |-> motor_state_out == 3'h0) else $error("runs asleep");
  c_brake: cover property (motor_state_out == 3'h6);
  c_coast: cover property (motor_state_out == 3'h4);
  c_sleep: cover property (power_state_out == 2'h3);
endmodule // mcpi_top_chk

bind mcpi_top mcpi_top_chk u_chk (.clk_in, .reset_in, .brake_pin_in, .dir_pin_in, .output_disable_pin_in,
  .hs_en_out, .ls_en_out, .motor_state_out, .power_state_out, .speed_ref_out, .dir_eff_out,
  .fault_indicator_n_out, .fault_status_out, .cfg_out);

/* verification/mcpi_ctl_model.sv */
/* Controller model: speed/wake pin as a 256-cycle PWM.
   Assumes duty_in changes on clk_in; 0 holds the pin low. */
`timescale 1ns/1ns
module mcpi_ctl_model (
  input wire logic clk_in,
  input wire logic [7:0] duty_in,
  output logic speed_pin_out = 1'b0
);
  logic [7:0] cnt_ff = 8'h00;
  always_ff @(posedge clk_in)
  begin
    cnt_ff <= cnt_ff + 8'h01;
    speed_pin_out <= (cnt_ff < duty_in);
  end
endmodule // mcpi_ctl_model

/* verification/tb_top.sv */
/* Bench for mcpi_top: speed modes, brake, direction, disable, faults,
   sleep and save. Assumes mcpi_ctl_model drives the speed pin. */
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic clk_in, reset_in, brake_pin_in, dir_pin_in, output_disable_pin_in, speed_wake_pin_in;
  logic cfg_wr_in, nvm_save_in, dir_eff_out, fault_indicator_n_out, nvm_wr_out;
  logic [7:0] adc_speed_code_in, fault_events_in, fault_clear_in, duty, ev;
  logic [7:0] speed_ref_out, speed_cmd_out, fault_status_out;
  logic [2:0] hs_en_out, ls_en_out, motor_state_out;
  logic [1:0] power_state_out;
  logic [27:0] cfg_data_in, nvm_rd_data_in, cfg_out, nvm_wr_data_out;
  mcpi_pkg::mcpi_cfg_t c;
  int num_errors = 0;
  int n_tests = 0;
  int m;
  mcpi_ctl_model u_ctl (.clk_in, .duty_in(duty), .speed_pin_out(speed_wake_pin_in));
  // Short sleep count keeps the run brief
  mcpi_top #(.SLEEP_ENTRY_CYC(50)) dut (.clk_in, .reset_in, .brake_pin_in, .dir_pin_in, .output_disable_pin_in,
    .speed_wake_pin_in, .adc_speed_code_in, .cfg_wr_in, .cfg_data_in, .nvm_save_in, .nvm_rd_data_in,
    .fault_events_in, .fault_clear_in, .hs_en_out, .ls_en_out, .motor_state_out, .power_state_out,
    .speed_ref_out, .speed_cmd_out, .dir_eff_out, .fault_indicator_n_out, .fault_status_out, .cfg_out,
    .nvm_wr_out, .nvm_wr_data_out);
  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wcfg;
    cyc(1);
    cfg_data_in <= c;
    cfg_wr_in <= 1'b1;
    cyc(1);
    cfg_wr_in <= 1'b0;
    cyc(2);
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int k = 0; k < 20000 && motor_state_out !== s; k++)
      cyc(1);
    #1;
    if (motor_state_out !== s)
    begin
      num_errors++;
      test_done();
    end
  endtask
  function automatic logic [7:0] exp_spd(input int md);
    return md == 0 ? duty : md == 1 ? 8'h01 : adc_speed_code_in;
  endfunction
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial
  begin
    {reset_in, brake_pin_in, dir_pin_in, output_disable_pin_in, cfg_wr_in, nvm_save_in} = 6'h20;
    {adc_speed_code_in, fault_events_in, fault_clear_in, duty} = 32'h000000FF;
    cfg_data_in = 28'h0000000;
    nvm_rd_data_in = 28'h5A30C80;
    c = mcpi_pkg::CFG_RESET_VAL;
    m = $urandom(42);
    cyc(4);
    reset_in <= 1'b0;
    cyc(3);
    #1;
    `CHK("fault_n", 1'b1, fault_indicator_n_out)
    `CHK("state", 3'h0, motor_state_out)
    `CHK("boot_cfg", 28'h5A30C80, cfg_out)
    // Low runs stay under the sleep count
    for (m = 0; m < 3; m++)
    begin
      c.speed_mode = mcpi_pkg::mcpi_spd_mode_t'(m);
      cyc(1);
      duty <= 8'hD8 + 8'($urandom_range(32'h27));
      adc_speed_code_in <= 8'h40 + 8'($urandom_range(32'hBF));
      wcfg();
      cyc(800);
      #1;
      `CHK("speed_cmd", exp_spd(m), speed_cmd_out)
    end
    c.speed_mode = mcpi_pkg::MCPI_SPD_I2C;
    c.i2c_speed = 8'hC0;
    c.brake_speed_thr = 8'h20;
    c.ramp_step = 4'h8;
    cyc(1);
    duty <= 8'hFF;
    wcfg();
    wait_st(3'h3);
    cyc(2600);
    #1;
    `CHK("serial_cmd", 8'hC0, speed_cmd_out)
    cyc(1);
    brake_pin_in <= 1'b1;
    wait_st(3'h6);
    `CHK("ls_brake", 6'h07, {hs_en_out, ls_en_out})
    `CHK("brake_spd", 1'b1, speed_ref_out <= 8'h20)
    cyc(50);
    #1;
    `CHK("brake_hold", 3'h6, motor_state_out)
    cyc(1);
    brake_pin_in <= 1'b0;
    wait_st(3'h3);
    {c.brake_align, c.brake_ovr_en, c.brake_ovr_val} = 3'h7;
    wcfg();
    wait_st(3'h6);
    `CHK("align", 6'h0E, {hs_en_out, ls_en_out})
    {c.brake_align, c.brake_ovr_en} = 2'h0;
    wcfg();
    wait_st(3'h3);
    for (m = 0; m < 8; m++)
    begin
      {c.dir_ovr_en, c.dir_ovr_val} = 2'(m);
      cyc(1);
      dir_pin_in <= m[2];
      wcfg();
      cyc(4);
      #1;
      `CHK("dir", m[1] ? m[0] : m[2], dir_eff_out)
    end
    cyc(1);
    output_disable_pin_in <= 1'b1;
    cyc(5);
    #1;
    `CHK("coast", 9'h100, {motor_state_out, hs_en_out, ls_en_out})
    `CHK("pwr", 2'h0, power_state_out)
    `CHK("flt", 2'h2, {fault_status_out[7], fault_indicator_n_out})
    cyc(1);
    output_disable_pin_in <= 1'b0;
    cyc(4);
    #1;
    `CHK("restart", 3'h1, motor_state_out)
    ev = 8'($urandom_range(32'hFF)) | 8'h01;
    cyc(1);
    fault_clear_in <= 8'hFF;
    cyc(1);
    fault_events_in <= ev;
    cyc(1);
    fault_clear_in <= 8'h00;
    fault_events_in <= 8'h00;
    cyc(1);
    #1;
    `CHK("fault_set", ev, fault_status_out)
    `CHK("fault_pin", 1'b0, fault_indicator_n_out)
    c.sleep_sel = 1'b1;
    wcfg();
    duty <= 8'h00;
    cyc(80);
    #1;
    `CHK("sleep", 5'h18, {power_state_out, motor_state_out})
    cyc(1);
    duty <= 8'hFF;
    cyc(6);
    #1;
    `CHK("wake", 2'h0, power_state_out)
    cyc(1);
    nvm_save_in <= 1'b1;
    cyc(1);
    nvm_save_in <= 1'b0;
    #1;
    `CHK("nvm_wr", 1'b1, nvm_wr_out)
    cyc(1);
    #1;
    `CHK("nvm", c, nvm_wr_data_out)
    test_done();
  end
endmodule // tb_top
